//--- mst_core.sv
`timescale 1ns/1ps
`default_nettype none
module mst_core
  import mst_pkg::*;
(
  input  wire logic              core_clk_i,
  input  wire logic              rst_i,
  input  wire logic              issue_i,
  input  wire logic [4:0]        op_i,
  input  wire logic              to_acc_i,
  input  wire logic [2:0]        bit_sel_i,
  input  wire logic [7:0]        imm_i,
  input  wire logic [ADDR_W-1:0] mem_addr_i,
  input  wire logic [7:0]        mem_rdata_i,
  input  wire logic [PROG_W-1:0] prog_data_i,
  input  wire logic [7:0]        tbl_ptr_high_i,
  input  wire logic              tbl_ptr_high_we_i,
  input  wire logic [7:0]        tbl_ptr_low_i,
  input  wire logic              tbl_ptr_low_we_i,
  input  wire logic [7:0]        acc_i,
  input  wire logic              acc_we_i,
  input  wire logic [7:0]        last_page_i,
  output logic                   ready_o,
  output logic [ADDR_W-1:0]      mem_addr_o,
  output logic                   mem_re_o,
  output logic [ADDR_W-1:0]      prog_addr_o,
  output logic                   prog_re_o,
  output logic                   mem_we_o,
  output logic [ADDR_W-1:0]      mem_waddr_o,
  output logic [7:0]             mem_wdata_o,
  output logic [7:0]             acc_o,
  output logic [7:0]             table_pointer_low_o,
  output logic [7:0]             table_pointer_high_o,
  output logic [7:0]             table_high_latch_o,
  output logic                   zero_flag_o,
  output logic                   carry_flag_o,
  output logic                   half_carry_flag_o,
  output logic                   signed_range_flag_o,
  output logic                   signed_carry_flag_o,
  output logic                   skip_o,
  output logic                   dummy_o,
  output logic                   done_o
);

  // ****************************************************
  // Decode and operand selection
  // ****************************************************
  mst_op_e    op;
  mst_state_e state_q;
  mst_state_e state_d;
  logic [7:0] acc_q;
  logic [7:0] tbl_low_q;
  logic [7:0] tbl_high_q;
  logic [7:0] latch_q;
  logic       z_q;
  logic       c_q;
  logic       ac_q;
  logic       ov_q;
  logic       sc_q;
  logic [7:0] tbl_low_inc;
  logic [7:0] tbl_low_use;
  logic [7:0] add_b;
  logic       add_cin;
  logic [7:0] add_sum;
  logic       add_c;
  logic       add_h;
  logic       add_ov;
  logic [7:0] daa_add;
  logic [8:0] daa_sum;
  logic [7:0] res;
  logic       res_to_mem;
  logic       res_to_acc;
  logic       upd_z;
  logic       upd_arith;
  logic       upd_daa_c;
  logic       is_skip;
  logic       skip_cond;
  logic       is_table;
  logic       pre_inc;
  logic       exec;

  assign op      = mst_op_e'(op_i);
  assign ready_o = (state_q == ST_EXEC);
  assign exec    = issue_i && ready_o;

  // ****************************************************
  // Table pointer addressing
  // ****************************************************
  assign tbl_low_inc = tbl_low_q + ONE_BYTE;
  assign pre_inc     = (op == OP_TBL_PRE_PAGED) || (op == OP_TBL_PRE_LAST);
  assign tbl_low_use = pre_inc ? tbl_low_inc : tbl_low_q;
  assign is_table    = (op == OP_TBL_PAGED) || (op == OP_TBL_LAST) || pre_inc;

  always_comb begin
    prog_addr_o = {tbl_high_q, tbl_low_use};
    if ((op == OP_TBL_LAST) || (op == OP_TBL_PRE_LAST)) begin
      prog_addr_o = {last_page_i, tbl_low_use};
    end
  end
  assign prog_re_o  = exec && is_table;
  // Full-width address reaches every data memory section directly
  assign mem_addr_o = mem_addr_i;
  assign mem_re_o   = exec && !is_table && (op != OP_XOR_IMM) && (op != OP_NONE);

  // ****************************************************
  // Arithmetic
  // ****************************************************
  assign add_b   = mem_rdata_i;
  assign add_cin = (op == OP_ADD_CARRY) ? c_q : 1'b0;

  mst_adder u_adder (
    .a_i     (acc_q),
    .b_i     (add_b),
    .cin_i   (add_cin),
    .sum_o   (add_sum),
    .carry_o (add_c),
    .half_o  (add_h),
    .ovf_o   (add_ov)
  );

  always_comb begin
    daa_add = ZERO_BYTE;
    if ((acc_q[3:0] > BCD_LIMIT) || ac_q) begin
      daa_add[3:0] = BCD_ADJ;
    end
    if ((acc_q[7:4] > BCD_LIMIT) || c_q) begin
      daa_add[7:4] = BCD_ADJ;
    end
  end
  // Low nibble adjust can push the high nibble past nine, so sum in full
  assign daa_sum = {1'b0, acc_q} + {1'b0, daa_add};

  // ****************************************************
  // Result mux
  // ****************************************************
  always_comb begin
    res        = ZERO_BYTE;
    res_to_mem = 1'b0;
    res_to_acc = 1'b0;
    upd_z      = 1'b0;
    upd_arith  = 1'b0;
    upd_daa_c  = 1'b0;
    is_skip    = 1'b0;
    skip_cond  = 1'b0;
    case (op)
      OP_SKIP_ZERO: begin
        res        = mem_rdata_i;
        res_to_mem = 1'b1;
        is_skip    = 1'b1;
        skip_cond  = (mem_rdata_i == ZERO_BYTE);
      end
      OP_SKIP_ZCOPY: begin
        res        = mem_rdata_i;
        res_to_acc = 1'b1;
        is_skip    = 1'b1;
        skip_cond  = (mem_rdata_i == ZERO_BYTE);
      end
      OP_SKIP_BIT_ZERO: begin
        is_skip   = 1'b1;
        skip_cond = !mem_rdata_i[bit_sel_i];
      end
      OP_TBL_PAGED, OP_TBL_LAST, OP_TBL_PRE_PAGED, OP_TBL_PRE_LAST: begin
        res        = prog_data_i[7:0];
        res_to_mem = 1'b1;
      end
      OP_XOR: begin
        res        = acc_q ^ mem_rdata_i;
        res_to_mem = !to_acc_i;
        res_to_acc = to_acc_i;
        upd_z      = 1'b1;
      end
      OP_XOR_IMM: begin
        res        = acc_q ^ imm_i;
        res_to_acc = 1'b1;
        upd_z      = 1'b1;
      end
      OP_ADD_CARRY, OP_ADD: begin
        res        = add_sum;
        res_to_mem = !to_acc_i;
        res_to_acc = to_acc_i;
        upd_arith  = 1'b1;
      end
      OP_AND: begin
        res        = acc_q & mem_rdata_i;
        res_to_mem = !to_acc_i;
        res_to_acc = to_acc_i;
        upd_z      = 1'b1;
      end
      OP_OR: begin
        res        = acc_q | mem_rdata_i;
        res_to_mem = !to_acc_i;
        res_to_acc = to_acc_i;
        upd_z      = 1'b1;
      end
      OP_CLEAR: begin
        res        = ZERO_BYTE;
        res_to_mem = 1'b1;
      end
      OP_CLEAR_BIT: begin
        res            = mem_rdata_i;
        res[bit_sel_i] = 1'b0;
        res_to_mem     = 1'b1;
      end
      OP_INVERT: begin
        res        = ~mem_rdata_i;
        res_to_mem = !to_acc_i;
        res_to_acc = to_acc_i;
        upd_z      = 1'b1;
      end
      OP_DEC_ADJ: begin
        res        = daa_sum[7:0];
        res_to_mem = 1'b1;
        upd_daa_c  = 1'b1;
      end
      OP_DEC: begin
        res        = mem_rdata_i - ONE_BYTE;
        res_to_mem = !to_acc_i;
        res_to_acc = to_acc_i;
        upd_z      = 1'b1;
      end
      OP_INC: begin
        res        = mem_rdata_i + ONE_BYTE;
        res_to_mem = !to_acc_i;
        res_to_acc = to_acc_i;
        upd_z      = 1'b1;
      end
      OP_MOVE_TO_ACC: begin
        res        = mem_rdata_i;
        res_to_acc = 1'b1;
      end
      OP_MOVE_TO_MEM: begin
        res        = acc_q;
        res_to_mem = 1'b1;
      end
      default: begin
        res = ZERO_BYTE;
      end
    endcase
  end

  // ****************************************************
  // Sequencing
  // ****************************************************
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_EXEC: begin
        if (exec && is_skip && skip_cond) begin
          state_d = ST_DUMMY;
        end
      end
      ST_DUMMY: begin
        state_d = ST_EXEC;
      end
      default: begin
        state_d = ST_EXEC;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state_q <= ST_EXEC;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      skip_o  <= 1'b0;
      dummy_o <= 1'b0;
      done_o  <= 1'b0;
    end else begin
      skip_o  <= exec && is_skip && skip_cond;
      dummy_o <= (state_q == ST_DUMMY);
      // Untaken skip retires at once, taken one on the same edge that raises dummy_o
      done_o  <= (exec && !(is_skip && skip_cond)) || (state_q == ST_DUMMY);
    end
  end

  // ****************************************************
  // Memory write port
  // ****************************************************
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      mem_we_o    <= 1'b0;
      mem_waddr_o <= '0;
      mem_wdata_o <= ZERO_BYTE;
    end else begin
      mem_we_o <= exec && res_to_mem;
      if (exec && res_to_mem) begin
        mem_waddr_o <= mem_addr_i;
        mem_wdata_o <= res;
      end
    end
  end

  // ****************************************************
  // Accumulator and table registers
  // ****************************************************
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      acc_q <= ACC_RST;
    end else if (exec && res_to_acc) begin
      acc_q <= res;
    end else if (acc_we_i) begin
      acc_q <= acc_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      tbl_low_q <= TBL_RST;
    end else if (exec && pre_inc) begin
      tbl_low_q <= tbl_low_inc;
    end else if (tbl_ptr_low_we_i) begin
      tbl_low_q <= tbl_ptr_low_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      tbl_high_q <= TBL_RST;
    end else if (tbl_ptr_high_we_i) begin
      tbl_high_q <= tbl_ptr_high_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      latch_q <= TBL_RST;
    end else if (exec && is_table) begin
      latch_q <= prog_data_i[15:8];
    end
  end

  // ****************************************************
  // Status flags
  // ****************************************************
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      z_q  <= 1'b0;
      c_q  <= 1'b0;
      ac_q <= 1'b0;
      ov_q <= 1'b0;
      sc_q <= 1'b0;
    end else if (exec) begin
      if (upd_z || upd_arith) begin
        z_q <= (res == ZERO_BYTE);
      end
      if (upd_arith) begin
        c_q  <= add_c;
        ac_q <= add_h;
        ov_q <= add_ov;
        sc_q <= add_ov ^ add_c;
      end
      if (upd_daa_c) begin
        // Carry is only set here so a prior carry chains through
        c_q <= daa_sum[8] || c_q;
      end
    end
  end

  assign acc_o                = acc_q;
  assign table_pointer_low_o  = tbl_low_q;
  assign table_pointer_high_o = tbl_high_q;
  assign table_high_latch_o   = latch_q;
  assign zero_flag_o          = z_q;
  assign carry_flag_o         = c_q;
  assign half_carry_flag_o    = ac_q;
  assign signed_range_flag_o  = ov_q;
  assign signed_carry_flag_o  = sc_q;

endmodule
`default_nettype wire

//--- mst_pkg.sv
package mst_pkg;
  // Operation selector codes
  typedef enum logic [4:0] {
    OP_NONE          = 5'h00,
    OP_SKIP_ZERO     = 5'h01,
    OP_SKIP_ZCOPY    = 5'h02,
    OP_SKIP_BIT_ZERO = 5'h03,
    OP_TBL_PAGED     = 5'h04,
    OP_TBL_LAST      = 5'h05,
    OP_TBL_PRE_PAGED = 5'h06,
    OP_TBL_PRE_LAST  = 5'h07,
    OP_XOR           = 5'h08,
    OP_XOR_IMM       = 5'h09,
    OP_ADD_CARRY     = 5'h0a,
    OP_ADD           = 5'h0b,
    OP_AND           = 5'h0c,
    OP_OR            = 5'h0d,
    OP_CLEAR         = 5'h0e,
    OP_CLEAR_BIT     = 5'h0f,
    OP_INVERT        = 5'h10,
    OP_DEC_ADJ       = 5'h11,
    OP_DEC           = 5'h12,
    OP_INC           = 5'h13,
    OP_MOVE_TO_ACC   = 5'h14,
    OP_MOVE_TO_MEM   = 5'h15
  } mst_op_e;

  typedef enum logic [1:0] {
    ST_EXEC  = 2'b01,
    ST_DUMMY = 2'b10
  } mst_state_e;

  localparam int unsigned DATA_W     = 8;
  localparam int unsigned ADDR_W     = 16;
  localparam int unsigned PROG_W     = 16;
  localparam logic [7:0]  ACC_RST    = 8'h00;
  localparam logic [7:0]  TBL_RST    = 8'h00;
  localparam logic [7:0]  LAST_PAGE  = 8'hff;
  localparam logic [3:0]  BCD_LIMIT  = 4'h9;
  localparam logic [3:0]  BCD_ADJ    = 4'h6;
  localparam logic [7:0]  ONE_BYTE   = 8'h01;
  localparam logic [7:0]  ZERO_BYTE  = 8'h00;
endpackage

//--- mst_adder.sv
`timescale 1ns/1ps
`default_nettype none
module mst_adder
  import mst_pkg::*;
(
  input  wire logic [7:0] a_i,
  input  wire logic [7:0] b_i,
  input  wire logic       cin_i,
  output logic      [7:0] sum_o,
  output logic            carry_o,
  output logic            half_o,
  output logic            ovf_o
);
  logic [4:0] low;
  logic [8:0] full;

  always_comb begin
    low     = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]} + {4'h0, cin_i};
    full    = {1'b0, a_i} + {1'b0, b_i} + {8'h00, cin_i};
    sum_o   = full[7:0];
    carry_o = full[8];
    half_o  = low[4];
    ovf_o   = (a_i[7] == b_i[7]) && (full[7] != a_i[7]);
  end
endmodule
`default_nettype wire

//--- mst_core_properties.sv
`timescale 1ns/1ps
`default_nettype none
module mst_core_chk
  import mst_pkg::*;
(
  input wire logic        core_clk_i,
  input wire logic        rst_i,
  input wire logic        issue_i,
  input wire logic [4:0]  op_i,
  input wire logic [7:0]  mem_rdata_i,
  input wire logic [15:0] prog_data_i,
  input wire logic [2:0]  bit_sel_i,
  input wire logic [7:0]  last_page_i,
  input wire logic        ready_o,
  input wire logic [15:0] prog_addr_o,
  input wire logic        mem_we_o,
  input wire logic [7:0]  mem_wdata_o,
  input wire logic [7:0]  table_pointer_low_o,
  input wire logic [7:0]  table_high_latch_o,
  input wire logic        skip_o,
  input wire logic        dummy_o,
  input wire logic        done_o
);
  // ********
  // Properties
  // ********
  logic tk;
  assign tk = issue_i && ready_o;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  a_zero_skip_taken: assert property (tk && op_i == OP_SKIP_ZERO && mem_rdata_i == 8'h00
    |=> skip_o && !ready_o) else $error("zero skip missing");
  a_skip_dummy_slot: assert property (skip_o |-> !ready_o ##1 (dummy_o && done_o && ready_o))
    else $error("dummy cycle wrong");
  a_bit_set_untaken: assert property (tk && op_i == OP_SKIP_BIT_ZERO && mem_rdata_i[bit_sel_i]
    |=> done_o && !skip_o && ready_o) else $error("bit skip wrong");
  a_zero_write_back: assert property (tk && op_i == OP_SKIP_ZERO
    |=> mem_we_o && mem_wdata_o == $past(mem_rdata_i)) else $error("write back wrong");
  a_table_word_split: assert property (tk && op_i inside {[OP_TBL_PAGED:OP_TBL_PRE_LAST]}
    |=> mem_we_o && {table_high_latch_o, mem_wdata_o} == $past(prog_data_i))
    else $error("table split wrong");
  a_last_page_addr: assert property (tk && op_i == OP_TBL_LAST
    |-> prog_addr_o == {last_page_i, table_pointer_low_o}) else $error("last page addr wrong");
  a_preinc_low_bump: assert property (tk && op_i inside {OP_TBL_PRE_PAGED, OP_TBL_PRE_LAST}
    |=> table_pointer_low_o == 8'($past(table_pointer_low_o) + 8'h01)) else $error("no bump");
  a_clear_writes_zero: assert property (tk && op_i == OP_CLEAR
    |=> mem_we_o && mem_wdata_o == 8'h00) else $error("clear wrong");
endmodule

bind mst_core mst_core_chk chk_u (.core_clk_i, .rst_i, .issue_i, .op_i, .mem_rdata_i,
  .prog_data_i, .bit_sel_i, .last_page_i, .ready_o, .prog_addr_o, .mem_we_o, .mem_wdata_o,
  .table_pointer_low_o, .table_high_latch_o, .skip_o, .dummy_o, .done_o);
`default_nettype wire

//--- tb_mcu_skip_table_ext_ops.sv
`timescale 1ns/1ps
`default_nettype none
module tb_mcu_skip_table_ext_ops
  import mst_pkg::*;
;
  // ********
  // Signals
  // ********
  logic        core_clk_i, rst_i, issue_i, to_acc_i, acc_we_i, tbl_ptr_high_we_i;
  logic        tbl_ptr_low_we_i, ready_o, mem_re_o, prog_re_o, mem_we_o, zero_flag_o;
  logic        carry_flag_o, half_carry_flag_o, signed_range_flag_o, signed_carry_flag_o;
  logic        skip_o, dummy_o, done_o;
  logic [4:0]  op_i;
  logic [2:0]  bit_sel_i;
  logic [7:0]  imm_i, mem_rdata_i, tbl_ptr_high_i, tbl_ptr_low_i, acc_i, last_page_i;
  logic [7:0]  mem_wdata_o, acc_o, table_pointer_low_o, table_pointer_high_o, table_high_latch_o;
  logic [15:0] mem_addr_i, prog_data_i, mem_addr_o, prog_addr_o, mem_waddr_o, pa;
  logic [26:0] r;
  logic [28:0] t;
  logic [1:0]  pr;
  int          n_mismatch, tests_run;
  // Row: op, to_acc, operand, result, flags {z,c,ac,ov,sc}
  logic [26:0] ops [27] = '{
    {OP_ADD, 1'b1, 8'h01, 8'h80, 5'h07}, {OP_ADD, 1'b1, 8'h80, 8'h00, 5'h1a},
    {OP_ADD_CARRY, 1'b0, 8'h10, 8'h11, 5'h00}, {OP_ADD, 1'b1, 8'h7d, 8'h7d, 5'h00},
    {OP_DEC_ADJ, 1'b0, 8'h00, 8'h83, 5'h00}, {OP_MOVE_TO_ACC, 1'b1, 8'ha2, 8'ha2, 5'h00},
    {OP_DEC_ADJ, 1'b0, 8'h00, 8'h02, 5'h08}, {OP_MOVE_TO_ACC, 1'b1, 8'h09, 8'h09, 5'h08},
    {OP_ADD_CARRY, 1'b1, 8'h08, 8'h12, 5'h04}, {OP_DEC_ADJ, 1'b0, 8'h00, 8'h18, 5'h04},
    {OP_MOVE_TO_ACC, 1'b1, 8'hf0, 8'hf0, 5'h04}, {OP_XOR, 1'b0, 8'h3c, 8'hcc, 5'h04},
    {OP_AND, 1'b0, 8'h3c, 8'h30, 5'h04}, {OP_OR, 1'b0, 8'h3c, 8'hfc, 5'h04},
    {OP_AND, 1'b1, 8'h0f, 8'h00, 5'h14}, {OP_XOR, 1'b1, 8'h5a, 8'h5a, 5'h04},
    {OP_XOR_IMM, 1'b1, 8'h00, 8'h00, 5'h14}, {OP_INVERT, 1'b0, 8'hff, 8'h00, 5'h14},
    {OP_INVERT, 1'b1, 8'h0f, 8'hf0, 5'h04}, {OP_DEC, 1'b1, 8'h01, 8'h00, 5'h14},
    {OP_DEC, 1'b0, 8'h00, 8'hff, 5'h04}, {OP_INC, 1'b0, 8'hff, 8'h00, 5'h14},
    {OP_INC, 1'b1, 8'h7f, 8'h80, 5'h04}, {OP_CLEAR, 1'b0, 8'h5a, 8'h00, 5'h04},
    {OP_CLEAR_BIT, 1'b0, 8'hff, 8'hf7, 5'h04}, {OP_MOVE_TO_MEM, 1'b0, 8'h11, 8'h80, 5'h04},
    {OP_MOVE_TO_ACC, 1'b1, 8'h00, 8'h00, 5'h04}};
  // Row: op, program address, low pointer after
  logic [28:0] tbl [4] = '{{OP_TBL_PAGED, 16'h1234, 8'h34}, {OP_TBL_LAST, 16'hff34, 8'h34},
    {OP_TBL_PRE_PAGED, 16'h1235, 8'h35}, {OP_TBL_PRE_LAST, 16'hff36, 8'h36}};

  mst_core dut_u (
    .core_clk_i, .rst_i, .issue_i, .op_i, .to_acc_i, .bit_sel_i, .imm_i, .mem_addr_i,
    .mem_rdata_i, .prog_data_i, .tbl_ptr_high_i, .tbl_ptr_high_we_i, .tbl_ptr_low_i,
    .tbl_ptr_low_we_i, .acc_i, .acc_we_i, .last_page_i, .ready_o, .mem_addr_o, .mem_re_o,
    .prog_addr_o, .prog_re_o, .mem_we_o, .mem_waddr_o, .mem_wdata_o, .acc_o,
    .table_pointer_low_o, .table_pointer_high_o, .table_high_latch_o, .zero_flag_o,
    .carry_flag_o, .half_carry_flag_o, .signed_range_flag_o, .signed_carry_flag_o,
    .skip_o, .dummy_o, .done_o);

  // ********
  // Tasks
  // ********
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp(nm, {8'h00, e}, {8'h00, g});
  endtask

  task automatic chka(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp(nm, e, g);
  endtask

  task automatic chkf(input logic [4:0] e);
    cmp("flags", {11'h0, e}, {11'h0, zero_flag_o, carry_flag_o, half_carry_flag_o,
      signed_range_flag_o, signed_carry_flag_o});
  endtask

  // Status {write, skip, dummy, done, ready}; mask hides what a case leaves open
  task automatic chks(input logic [4:0] e, input logic [4:0] m);
    cmp("status", {11'h0, e}, {11'h0, m & {mem_we_o, skip_o, dummy_o, done_o, ready_o}});
  endtask

  // Issue stays up after the taking edge so no signal is driven twice in a step
  task automatic run(input mst_op_e op, input logic ta, input logic [7:0] rd);
    int n;
    n = 0;
    while (ready_o !== 1'b1) begin
      @(posedge core_clk_i);
      #1;
      n++;
      if (n > 4) begin
        n_mismatch++;
        stop_test();
      end
    end
    op_i = op;
    to_acc_i = ta;
    mem_rdata_i = rd;
    issue_i = 1'b1;
    #2;
    pa = prog_addr_o;
    pr = {mem_re_o, prog_re_o};
    @(posedge core_clk_i);
    #1;
  endtask

  // ********
  // Sequence
  // ********
  initial begin
    {issue_i, to_acc_i, acc_we_i, tbl_ptr_high_we_i, tbl_ptr_low_we_i} = 5'h00;
    op_i = 5'h00;
    bit_sel_i = 3'h3;
    imm_i = 8'h5a;
    mem_addr_i = 16'hfe01;
    mem_rdata_i = 8'h00;
    prog_data_i = 16'h0000;
    {acc_i, tbl_ptr_high_i, tbl_ptr_low_i} = {8'h7f, 8'h12, 8'h34};
    last_page_i = 8'hff;
    n_mismatch = 0;
    tests_run = 0;
    rst_i = 1'b1;
    repeat (12) @(posedge core_clk_i);
    #1;
    rst_i = 1'b0;
    chk("acc", 8'h00, acc_o);
    chkf(5'h00);
    chks(5'h01, 5'h1f);
    {acc_we_i, tbl_ptr_high_we_i, tbl_ptr_low_we_i} = 3'h7;
    @(posedge core_clk_i);
    #1;
    {acc_we_i, tbl_ptr_high_we_i, tbl_ptr_low_we_i} = 3'h0;
    $display("test reset done");
    foreach (ops[i]) begin
      r = ops[i];
      run(mst_op_e'(r[26:22]), r[21], r[20:13]);
      chk("result", r[12:5], r[21] ? acc_o : mem_wdata_o);
      chkf(r[4:0]);
      chks({~r[21], 4'h3}, 5'h1f);
    end
    chka("write addr", 16'hfe01, mem_waddr_o);
    $display("test datapath done");
    run(OP_SKIP_ZERO, 1'b0, 8'h00);
    chks(5'h18, 5'h1f);
    op_i = OP_MOVE_TO_ACC;
    mem_rdata_i = 8'h33;
    @(posedge core_clk_i);
    #1;
    chks(5'h07, 5'h1f);
    chk("acc", 8'h00, acc_o);
    run(OP_SKIP_ZERO, 1'b0, 8'h05);
    chks(5'h13, 5'h1f);
    chk("write back", 8'h05, mem_wdata_o);
    cmp("read strobes", 16'h0002, {14'h0, pr});
    chka("read addr", 16'hfe01, mem_addr_o);
    run(OP_SKIP_ZCOPY, 1'b0, 8'h6c);
    chks(5'h03, 5'h0f);
    chk("acc", 8'h6c, acc_o);
    run(OP_SKIP_ZCOPY, 1'b0, 8'h00);
    chks(5'h08, 5'h0f);
    chk("acc", 8'h00, acc_o);
    bit_sel_i = 3'h2;
    run(OP_SKIP_BIT_ZERO, 1'b0, 8'h04);
    chks(5'h03, 5'h1f);
    run(OP_SKIP_BIT_ZERO, 1'b0, 8'hfb);
    chks(5'h08, 5'h1f);
    chkf(5'h04);
    $display("test skip done");
    foreach (tbl[i]) begin
      t = tbl[i];
      prog_data_i = {t[7:0], ~t[7:0]};
      run(mst_op_e'(t[28:24]), 1'b0, 8'h00);
      chka("prog addr", t[23:8], pa);
      chk("latch", t[7:0], table_high_latch_o);
      chk("low byte", ~t[7:0], mem_wdata_o);
      chk("ptr low", t[7:0], table_pointer_low_o);
      cmp("read strobes", 16'h0001, {14'h0, pr});
      chk("ptr high", 8'h12, table_pointer_high_o);
    end
    $display("test table done");
    stop_test();
  end
endmodule
`default_nettype wire
